// file: hw/run_gate_cfg.svh
`ifndef RUN_GATE_CFG_SVH
`define RUN_GATE_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS      10
`define TICK_TIME_NS       1000000
`define TICK_CYCLES        (`TICK_TIME_NS / `CLK_PERIOD_NS)
// A tenth of a second counted in 1 ms ticks
`define TENTH_SEC_TICKS    20'h00064

// ****************************************************************
// Codes and modes
// ****************************************************************
`define RUN_EN_FUNC_CODE   6'h0D
`define STOP_COAST         2'h0
`define STOP_QSTOP         2'h1
`define STOP_QSTOP_RESUME  2'h2
`define CTRL_VF            3'h0
`define CTRL_VF_PG         3'h1
`define CTRL_SLIP_COMP     3'h2
`define CTRL_SENSORLESS    3'h3
`define CTRL_VECTOR        3'h4

// ****************************************************************
// Slip arithmetic and reset values
// ****************************************************************
`define SLIP_DIVISOR       32'h0000_0078
`define HZ_SCALE           32'h0000_0064
`define FREQ_RESET         16'h0000

`endif

// file: hw/run_gate_pkg.sv
package run_gate_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_RAMP   = 5'b00010,
    S_ADWELL = 5'b00100,
    S_DDWELL = 5'b01000,
    S_QSTOP  = 5'b10000
  } seq_state_t;

  typedef logic [15:0] freq_t;

endpackage

// file: hw/run_gate_dwell_sequencer.sv
`include "run_gate_cfg.svh"

module run_gate_dwell_sequencer
  import run_gate_pkg::*;
#(
  parameter int NUM_TERM    = 8,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire  logic                     clk,
  input  wire  logic                     rst_b,
  input  wire  logic                     run_cmd,
  input  wire  logic [NUM_TERM-1:0]      term_pin,
  input  wire  logic [NUM_TERM-1:0][5:0] terminal_function_code,
  input  wire  logic                     terminal_qualified,
  input  wire  logic [1:0]               dis_stop_mode,
  input  wire  logic [12:0]              qstop_time,
  input  wire  freq_t                    max_freq,
  input  wire  freq_t                    target_freq,
  input  wire  freq_t                    acc_step,
  input  wire  freq_t                    dec_step,
  input  wire  freq_t                    acc_dwell_freq,
  input  wire  logic [6:0]               acc_dwell_time,
  input  wire  freq_t                    dec_dwell_freq,
  input  wire  logic [6:0]               dec_dwell_time,
  input  wire  logic [2:0]               control_mode,
  input  wire  freq_t                    rated_freq,
  input  wire  logic [15:0]              rated_rpm,
  input  wire  logic [7:0]               pole_count,
  input  wire  logic [15:0]              rated_curr,
  input  wire  logic [15:0]              noload_curr,
  input  wire  logic [15:0]              out_curr,
  output logic [15:0]                    out_freq_q,
  output logic                           out_block_q,
  output logic                           dwelling_q,
  output logic                           run_enabled_q,
  output logic [15:0]                    rated_slip_q,
  output logic [15:0]                    slip_offset_q,
  output logic                           auto_comp_q
);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic                rst_m_q, rst_n_s;
  logic                run_m_q, run_s_q, run_d_q;
  logic [NUM_TERM-1:0] term_m_q, term_s_q;

  // Reset is asserted at once but released through two stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_s <= rst_m_q;
    end
  end

  // Pins are asynchronous to clk; the second stage is read, plus a third run stage for its edge
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      run_m_q  <= 1'b0;
      run_s_q  <= 1'b0;
      run_d_q  <= 1'b0;
      term_m_q <= '0;
      term_s_q <= '0;
    end else begin
      run_m_q  <= run_cmd;
      run_s_q  <= run_m_q;
      run_d_q  <= run_s_q;
      term_m_q <= term_pin;
      term_s_q <= term_m_q;
    end
  end

  default clocking dflt_cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  // ****************************************************************
  // Enable terminal decode
  // ****************************************************************
  logic [NUM_TERM-1:0] en_term_hit;
  for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
    // Any terminal carrying the enable code counts, OR-ed together
    assign en_term_hit[i] = term_s_q[i] &&
      (terminal_function_code[i] == `RUN_EN_FUNC_CODE);
  end

  logic en_hit, en_ok, run_rise, run_eff, relock_q;
  assign en_hit   = |en_term_hit;
  // Without the mode bit the terminal is ignored entirely
  assign en_ok    = !terminal_qualified || en_hit;
  assign run_rise = run_s_q && !run_d_q;
  assign run_eff  = run_s_q && !relock_q;

  // ****************************************************************
  // Ramp arithmetic
  // ****************************************************************
  function automatic freq_t ramp_to(freq_t cur, freq_t goal,
                                    freq_t up, freq_t dn);
    freq_t r;
    r = cur;
    if (cur < goal) begin
      r = (goal - cur <= up) ? goal : freq_t'(cur + up);
    end else if (cur > goal) begin
      r = (cur - goal <= dn) ? goal : freq_t'(cur - dn);
    end
    return r;
  endfunction

  seq_state_t  st_q, st_d;
  freq_t       freq_d;
  logic [19:0] tick_q, cnt_q, cnt_d, qacc_q, qacc_d;
  logic        tick, acc_done_q, acc_done_d, dec_done_q, dec_done_d;
  logic        block_d, relock_set;

  // Millisecond tick paces all ramps and dwell counts
  assign tick = (tick_q == 20'(TICK_CYCLES - 1));

  // Zero dwell time leaves the plateau unarmed
  logic pend_acc, pend_dec;
  assign pend_acc = !acc_done_q && (acc_dwell_time != 7'h00) &&
                    (target_freq > acc_dwell_freq) &&
                    (out_freq_q <= acc_dwell_freq);
  assign pend_dec = !dec_done_q && (dec_dwell_time != 7'h00) &&
                    (dec_dwell_freq != 16'h0000) &&
                    (out_freq_q >= dec_dwell_freq);

  logic [19:0] acc_dw_ticks, dec_dw_ticks, qstop_ticks;
  assign acc_dw_ticks = 20'(acc_dwell_time * `TENTH_SEC_TICKS);
  assign dec_dw_ticks = 20'(dec_dwell_time * `TENTH_SEC_TICKS);
  assign qstop_ticks  = 20'(qstop_time * `TENTH_SEC_TICKS);

  // Fractional quick-stop decrement: max_freq spread over the stop time
  logic [20:0] q_num, q_dec, q_rem;
  assign q_num = {1'b0, qacc_q} + {5'h00, max_freq};
  assign q_dec = (qstop_ticks == 20'h0) ? 21'h1FFFFF :
                 q_num / {1'b0, qstop_ticks};
  assign q_rem = (qstop_ticks == 20'h0) ? 21'h0 :
                 q_num % {1'b0, qstop_ticks};

  logic stop_drop;
  assign stop_drop = !en_ok && (st_q inside {S_RAMP, S_ADWELL, S_DDWELL});

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    st_d       = st_q;
    freq_d     = out_freq_q;
    cnt_d      = cnt_q;
    qacc_d     = qacc_q;
    acc_done_d = acc_done_q;
    dec_done_d = dec_done_q;
    block_d    = out_block_q;
    relock_set = 1'b0;
    if (stop_drop) begin
      if (dis_stop_mode == `STOP_COAST) begin
        st_d    = S_IDLE;
        freq_d  = `FREQ_RESET;
        block_d = 1'b1;
      end else begin
        st_d       = S_QSTOP;
        qacc_d     = 20'h0;
        relock_set = (dis_stop_mode == `STOP_QSTOP);
      end
    end else begin
      unique case (st_q)
        S_IDLE: begin
          freq_d = `FREQ_RESET;
          if (run_eff && en_ok) begin
            st_d       = S_RAMP;
            block_d    = 1'b0;
            acc_done_d = 1'b0;
            dec_done_d = 1'b0;
          end
        end
        S_RAMP: begin
          if (tick && run_eff) begin
            dec_done_d = 1'b0;
            if (pend_acc && out_freq_q == acc_dwell_freq) begin
              st_d  = S_ADWELL;
              cnt_d = 20'h0;
            end else begin
              freq_d = ramp_to(out_freq_q,
                         pend_acc ? acc_dwell_freq : target_freq,
                         acc_step, dec_step);
            end
          end else if (tick) begin
            if (pend_dec && out_freq_q == dec_dwell_freq) begin
              st_d  = S_DDWELL;
              cnt_d = 20'h0;
            end else if (out_freq_q == 16'h0000) begin
              st_d    = S_IDLE;
              block_d = 1'b1;
            end else begin
              freq_d = ramp_to(out_freq_q,
                         pend_dec ? dec_dwell_freq : 16'h0000,
                         acc_step, dec_step);
            end
          end
        end
        S_ADWELL: begin
          if (!run_eff) begin
            st_d = S_RAMP;
          end else if (tick) begin
            cnt_d = cnt_q + 20'h1;
            if (cnt_d >= acc_dw_ticks) begin
              st_d       = S_RAMP;
              acc_done_d = 1'b1;
            end
          end
        end
        S_DDWELL: begin
          if (run_eff) begin
            st_d = S_RAMP;
          end else if (tick) begin
            cnt_d = cnt_q + 20'h1;
            if (cnt_d >= dec_dw_ticks) begin
              st_d       = S_RAMP;
              dec_done_d = 1'b1;
            end
          end
        end
        S_QSTOP: begin
          if (dis_stop_mode == `STOP_QSTOP_RESUME && en_ok && run_s_q) begin
            st_d = S_RAMP;
          end else if (tick) begin
            qacc_d = q_rem[19:0];
            if ({5'h00, out_freq_q} <= q_dec) begin
              freq_d  = `FREQ_RESET;
              st_d    = S_IDLE;
              block_d = 1'b1;
            end else begin
              freq_d = out_freq_q - q_dec[15:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_q        <= S_IDLE;
      tick_q      <= 20'h0;
      cnt_q       <= 20'h0;
      qacc_q      <= 20'h0;
      acc_done_q  <= 1'b0;
      dec_done_q  <= 1'b0;
      out_freq_q  <= `FREQ_RESET;
      out_block_q <= 1'b1;
    end else begin
      st_q        <= st_d;
      tick_q      <= tick ? 20'h0 : tick_q + 20'h1;
      cnt_q       <= cnt_d;
      qacc_q      <= qacc_d;
      acc_done_q  <= acc_done_d;
      dec_done_q  <= dec_done_d;
      out_freq_q  <= freq_d;
      out_block_q <= block_d;
    end
  end

  // Fresh-command lock; a set in the edge's own cycle wins
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      relock_q <= 1'b0;
    end else begin
      relock_q <= relock_set || (relock_q && !run_rise);
    end
  end

  // ****************************************************************
  // Status and slip compensation
  // ****************************************************************
  logic [31:0] sync_hz, slip_w, load_num, load_den, off_w;
  logic [15:0] cur_clip;
  assign sync_hz  = (32'(rated_rpm) * 32'(pole_count) * `HZ_SCALE)
                    / `SLIP_DIVISOR;
  assign slip_w   = ({16'h0, rated_freq} > sync_hz) ?
                    {16'h0, rated_freq} - sync_hz : 32'h0;
  assign cur_clip = (out_curr > rated_curr) ? rated_curr : out_curr;
  assign load_num = (cur_clip > noload_curr) ?
                    32'(cur_clip - noload_curr) : 32'h0;
  assign load_den = (rated_curr > noload_curr) ?
                    32'(rated_curr - noload_curr) : 32'h0;
  // Offset scales with load current above the no-load current
  assign off_w    = (load_den == 32'h0) ? 32'h0 :
                    (32'(rated_slip_q) * load_num) / load_den;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dwelling_q    <= 1'b0;
      run_enabled_q <= 1'b0;
      rated_slip_q  <= 16'h0;
      slip_offset_q <= 16'h0;
      auto_comp_q   <= 1'b0;
    end else begin
      dwelling_q    <= (st_d == S_ADWELL) || (st_d == S_DDWELL);
      run_enabled_q <= en_ok;
      rated_slip_q  <= slip_w[15:0];
      slip_offset_q <= (control_mode == `CTRL_SLIP_COMP) ?
                       off_w[15:0] : 16'h0;
      // Closed-loop modes handle slip themselves; no offset there
      auto_comp_q   <= control_mode inside {`CTRL_VF_PG,
                         `CTRL_SENSORLESS, `CTRL_VECTOR};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_adwell;
    st_q == S_ADWELL ##1 st_q == S_ADWELL;
  endsequence
  sequence seq_ddwell;
    st_q == S_DDWELL ##1 st_q == S_DDWELL;
  endsequence

  AST_GATE_OFF: assert property (!terminal_qualified && run_eff &&
    st_q == S_IDLE |=> st_q == S_RAMP ##1 !out_block_q)
    else $error("run ignored with gating off");
  AST_GATE_ON: assert property (terminal_qualified && !en_hit &&
    st_q == S_IDLE |=> st_q == S_IDLE)
    else $error("run accepted without enable");
  AST_COAST: assert property (stop_drop &&
    dis_stop_mode == `STOP_COAST |=> out_freq_q == 16'h0 && out_block_q)
    else $error("coast stop did not block output");
  AST_QSTOP: assert property (stop_drop &&
    dis_stop_mode != `STOP_COAST |=> st_q == S_QSTOP && !out_block_q)
    else $error("quick stop not entered");
  AST_RELOCK: assert property (relock_q && !run_rise &&
    st_q == S_IDLE |=> st_q == S_IDLE)
    else $error("restart without fresh run command");
  AST_RESUME: assert property (st_q == S_QSTOP && en_ok && run_s_q &&
    dis_stop_mode == `STOP_QSTOP_RESUME |=> st_q == S_RAMP)
    else $error("quick stop did not resume");
  AST_ADWELL: assert property (seq_adwell |->
    $stable(out_freq_q) && out_freq_q == acc_dwell_freq)
    else $error("accel dwell plateau moved");
  AST_DDWELL: assert property (seq_ddwell |->
    $stable(out_freq_q) && out_freq_q == dec_dwell_freq)
    else $error("decel dwell plateau moved");
  AST_SKIP: assert property (st_q == S_RAMP &&
    acc_dwell_time == 7'h00 |=> st_q != S_ADWELL)
    else $error("dwell entered with zero time");
  AST_SLIP_MODE: assert property (control_mode != `CTRL_SLIP_COMP
    |=> slip_offset_q == 16'h0)
    else $error("slip offset outside slip mode");

endmodule

// file: tb/term_drv.sv
module term_drv #(
  parameter int EN_IDX = 3
) (
  input  wire logic       clk,
  input  wire logic       run_req,
  input  wire logic       en_req,
  output logic            run_cmd,
  output logic [7:0]      term_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] chatter_q;

  // ****************************************************************
  // Terminal contacts
  // ****************************************************************
  // Spare contacts chatter every cycle so only the coded terminal counts;
  // an unknown start falls into the else branch and settles at once
  always_ff @(posedge clk) begin
    if (chatter_q == 8'hA5) begin
      chatter_q <= 8'h5A;
    end else begin
      chatter_q <= 8'hA5;
    end
  end

  // Enable contact and run push-button follow the bench requests
  always_comb begin
    term_pin         = chatter_q;
    term_pin[EN_IDX] = en_req;
    run_cmd          = run_req;
  end
endmodule

// file: tb/run_gate_dwell_sequencer_tb_top.sv
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module run_gate_dwell_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import run_gate_pkg::*;

  typedef struct packed {
    logic tq; logic [5:0] code; logic en; logic [2:0] cm;
    logic [15:0] rpm; logic [15:0] cur; logic [15:0] slip;
    logic [15:0] off; logic auto; logic ren;
  } row_t;

  // Gating, code, enable, control mode and motor data beside the results
  localparam row_t ROWS [7] = '{
    '{1'b1, 6'h0D, 1'b1, 3'h0, 16'd1740, 16'd360, 16'd200, 16'd0, 1'b0, 1'b1},
    '{1'b1, 6'h0D, 1'b0, 3'h1, 16'd1740, 16'd360, 16'd200, 16'd0, 1'b1, 1'b0},
    '{1'b1, 6'h0C, 1'b1, 3'h2, 16'd1740, 16'd360, 16'd200, 16'd200, 1'b0, 1'b0},
    '{1'b0, 6'h0C, 1'b0, 3'h2, 16'd1740, 16'd260, 16'd200, 16'd100, 1'b0, 1'b1},
    '{1'b0, 6'h0D, 1'b0, 3'h2, 16'd1800, 16'd360, 16'd0, 16'd0, 1'b0, 1'b1},
    '{1'b0, 6'h00, 1'b1, 3'h3, 16'd1740, 16'd400, 16'd200, 16'd0, 1'b1, 1'b1},
    '{1'b1, 6'h0D, 1'b1, 3'h4, 16'd1740, 16'd360, 16'd200, 16'd0, 1'b1, 1'b1}
  };

  logic clk, rst_b, run_req, en_req, run_cmd, terminal_qualified;
  logic [7:0] term_pin;
  logic [7:0][5:0] terminal_function_code;
  logic [1:0] dis_stop_mode;
  logic [12:0] qstop_time;
  freq_t max_freq, target_freq, acc_step, dec_step;
  freq_t acc_dwell_freq, dec_dwell_freq, rated_freq;
  logic [6:0] acc_dwell_time, dec_dwell_time;
  logic [2:0] control_mode;
  logic [15:0] rated_rpm, rated_curr, noload_curr, out_curr;
  logic [7:0] pole_count;
  logic [15:0] out_freq_q, rated_slip_q, slip_offset_q;
  logic out_block_q, dwelling_q, run_enabled_q, auto_comp_q;
  int n_fail, cmp_count, c;
  logic seen;

  term_drv far_u (.clk, .run_req, .en_req, .run_cmd, .term_pin);

  run_gate_dwell_sequencer #(.NUM_TERM(8), .TICK_CYCLES(10)) dut_u (
    .clk, .rst_b, .run_cmd, .term_pin, .terminal_function_code,
    .terminal_qualified, .dis_stop_mode, .qstop_time, .max_freq,
    .target_freq, .acc_step, .dec_step, .acc_dwell_freq, .acc_dwell_time,
    .dec_dwell_freq, .dec_dwell_time, .control_mode, .rated_freq,
    .rated_rpm, .pole_count, .rated_curr, .noload_curr, .out_curr,
    .out_freq_q, .out_block_q, .dwelling_q, .run_enabled_q, .rated_slip_q,
    .slip_offset_q, .auto_comp_q);

  // ****************************************************************
  // Clock, closing and waits
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang in any wait ends the run the same way as the tests do
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  // Bounded wait: 0 block flag, 1 dwell flag, 2 frequency
  task automatic wait_on(input int sel, input logic [15:0] v, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      if (sel == 0 && out_block_q === v[0]) break;
      if (sel == 1 && dwelling_q === v[0]) break;
      if (sel == 2 && out_freq_q === v) break;
    end
    cmp_count++;
    if (k == n) begin
      n_fail++;
      $display("BAD wait%0d exp %0h got timeout", sel, v);
    end
  endtask

  // Plateau length in clocks; expected 100 ticks of 10 clocks
  task automatic dwell_len();
    c = 0;
    while (dwelling_q === 1'b1 && c < 3000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  task automatic drive(input logic r, input logic e);
    @(posedge clk);
    run_req <= r;
    en_req <= e;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    n_fail = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    run_req = 1'b0;
    en_req = 1'b0;
    terminal_function_code = '0;
    terminal_qualified = 1'b0;
    dis_stop_mode = 2'h0;
    qstop_time = 13'h0001;
    max_freq = 16'h03E8;
    target_freq = 16'h03E8;
    acc_step = 16'h0064;
    dec_step = 16'h0064;
    acc_dwell_freq = 16'h01F4;
    dec_dwell_freq = 16'h01F4;
    acc_dwell_time = 7'h00;
    dec_dwell_time = 7'h00;
    control_mode = 3'h0;
    rated_freq = 16'h1770;
    rated_rpm = 16'h06CC;
    pole_count = 8'h04;
    rated_curr = 16'h0168;
    noload_curr = 16'h00A0;
    out_curr = 16'h0168;
    repeat (11) @(posedge clk);
    #1;
    `CHK("rst_block", 1'b1, out_block_q)
    `CHK("rst_freq", 16'h0000, out_freq_q)
    // Release on the twelfth edge, like every other input change
    @(posedge clk);
    rst_b <= 1'b1;
    $display("test reset done");
    // Static settings row by row, results read once settled
    foreach (ROWS[i]) begin
      @(posedge clk);
      terminal_qualified <= ROWS[i].tq;
      terminal_function_code[3] <= ROWS[i].code;
      en_req <= ROWS[i].en;
      control_mode <= ROWS[i].cm;
      rated_rpm <= ROWS[i].rpm;
      out_curr <= ROWS[i].cur;
      repeat (8) @(posedge clk);
      #1;
      `CHK("run_en", ROWS[i].ren, run_enabled_q)
      `CHK("rated_slip", ROWS[i].slip, rated_slip_q)
      `CHK("slip_offset", ROWS[i].off, slip_offset_q)
      `CHK("auto_comp", ROWS[i].auto, auto_comp_q)
    end
    $display("test table done");
    // Both plateaus with gating off
    @(posedge clk);
    terminal_qualified <= 1'b0;
    acc_dwell_time <= 7'h01;
    dec_dwell_time <= 7'h01;
    drive(1'b1, 1'b0);
    wait_on(1, 16'h0001, 200);
    `CHK("acc_plateau", 16'h01F4, out_freq_q)
    dwell_len();
    `CHK("acc_len", 1'b1, (c >= 990 && c <= 1010))
    wait_on(2, 16'h03E8, 200);
    drive(1'b0, 1'b0);
    wait_on(1, 16'h0001, 200);
    `CHK("dec_plateau", 16'h01F4, out_freq_q)
    dwell_len();
    `CHK("dec_len", 1'b1, (c >= 990 && c <= 1010))
    wait_on(0, 16'h0001, 200);
    `CHK("stop_freq", 16'h0000, out_freq_q)
    $display("test dwell done");
    // Zero dwell times ramp straight through
    @(posedge clk);
    acc_dwell_time <= 7'h00;
    dec_dwell_time <= 7'h00;
    drive(1'b1, 1'b0);
    seen = 1'b0;
    // Sample after the edge so the flag has settled
    repeat (300) begin
      @(posedge clk);
      #1;
      seen = seen | dwelling_q;
    end
    `CHK("no_dwell", 1'b0, seen)
    `CHK("no_dwell_freq", 16'h03E8, out_freq_q)
    drive(1'b0, 1'b0);
    wait_on(0, 16'h0001, 200);
    $display("test skip done");
    // Gated run, enable drops: coast
    @(posedge clk);
    terminal_qualified <= 1'b1;
    terminal_function_code[3] <= 6'h0D;
    drive(1'b1, 1'b1);
    wait_on(2, 16'h03E8, 200);
    drive(1'b1, 1'b0);
    wait_on(0, 16'h0001, 8);
    `CHK("coast_freq", 16'h0000, out_freq_q)
    // Run still held but enable off: gating must keep the output blocked
    repeat (20) @(posedge clk);
    #1;
    `CHK("gated_idle", 1'b1, out_block_q)
    drive(1'b1, 1'b1);
    wait_on(0, 16'h0000, 20);
    drive(1'b0, 1'b1);
    wait_on(0, 16'h0001, 400);
    $display("test coast done");
    // Quick-stop then relock until a fresh run edge
    @(posedge clk);
    dis_stop_mode <= 2'h1;
    drive(1'b1, 1'b1);
    wait_on(2, 16'h03E8, 200);
    drive(1'b1, 1'b0);
    repeat (300) @(posedge clk);
    #1;
    `CHK("qstop_ramp", 1'b0, out_block_q)
    `CHK("qstop_rate", 1'b1, (out_freq_q >= 600 && out_freq_q <= 800))
    wait_on(0, 16'h0001, 1500);
    drive(1'b1, 1'b1);
    repeat (300) @(posedge clk);
    #1;
    `CHK("relock", 1'b1, out_block_q)
    drive(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    drive(1'b1, 1'b1);
    wait_on(0, 16'h0000, 20);
    drive(1'b0, 1'b1);
    wait_on(0, 16'h0001, 400);
    $display("test qstop done");
    // Quick-stop with automatic resume
    @(posedge clk);
    dis_stop_mode <= 2'h2;
    drive(1'b1, 1'b1);
    wait_on(2, 16'h03E8, 200);
    drive(1'b1, 1'b0);
    repeat (300) @(posedge clk);
    drive(1'b1, 1'b1);
    wait_on(2, 16'h03E8, 400);
    `CHK("resume_block", 1'b0, out_block_q)
    $display("test resume done");
    give_verdict();
  end
endmodule
